// >>> rtl/cmpctl_top.v
`timescale 1ns/1ps
`include "cmpctl_map.vh"

// Function
// - Comparator runs only while enable set
// - Result readable in control and mirror
// - Pin driven when pin enable, output direction, enable
// - Pin enable overrides data latch regardless
// - Internal result registered once per instruction cycle
// - Pin gets raw result, not registered
// - Invert bit flips the reported result
// - Speed select resets to normal speed
// - Hysteresis follows hysteresis enable bit
// - Result offered as counter gate source
// - Edge select: rising, falling or both
// - Positive and negative input select fields
module cmpctl_top #(
    parameter CLKS_PER_CYCLE = `CMPCTL_CLKS_PER_CYCLE
) (
    // Clock and reset
    input  wire       ref_clk,
    input  wire       arst_n,
    // Register port
    input  wire [7:0] regAddr,
    input  wire [7:0] regWdata,
    input  wire       regWr,
    input  wire       regRd,
    output reg  [7:0] regRdata,
    // Analog front end
    input  wire       analogRaw,
    output wire       analogEnable,
    output wire       speedPowerSelect,
    output wire       hysteresisEnable,
    output wire [1:0] positiveInput,
    output wire [1:0] negativeInput,
    // Port pin
    input  wire       pinDirectionBit,
    input  wire       portLatch,
    output wire       pinOut,
    output wire       pinOe,
    // Counter gate
    output wire       gateSource,
    output wire       gateSyncEnable,
    // Interrupt
    output wire       irq
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg  [7:0] compControlZero;
    reg  [7:0] compControlOne;
    reg  [1:0] status;
    reg  [1:0] mask;
    reg        resultSync;
    reg        resultPrev;

    wire       tick;
    wire       compEnable   = compControlZero[`CMPCTL_C0_ENABLE];
    wire       resultInvert = compControlZero[`CMPCTL_C0_INVERT];
    wire       resultPinEn  = compControlZero[`CMPCTL_C0_PINEN];

    cmpctl_cycle_tick #(
        .CLKS (CLKS_PER_CYCLE)
    ) uTick (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .tick    (tick)
    );

    // ------------------------------------------------------------
    // Result path
    // ------------------------------------------------------------
    // A disabled comparator reads as low rather than a floating value.
    wire compResult = compEnable & (analogRaw ^ resultInvert);

    // Sampled only on the cycle tick so the gate, reads and edge flags see one value per cycle.
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            resultSync <= 1'b0;
            resultPrev <= 1'b0;
        end else if (tick) begin
            resultSync <= compResult;
            resultPrev <= resultSync;
        end
    end

    wire riseEvent = tick & resultSync & ~resultPrev & compControlOne[`CMPCTL_C1_RISE];
    wire fallEvent = tick & ~resultSync & resultPrev & compControlOne[`CMPCTL_C1_FALL];

    assign analogEnable     = compEnable;
    assign speedPowerSelect = compControlZero[`CMPCTL_C0_SPEED];
    assign hysteresisEnable = compControlZero[`CMPCTL_C0_HYST];
    assign positiveInput    = compControlOne[`CMPCTL_C1_POS_HI:`CMPCTL_C1_POS_LO];
    assign negativeInput    = compControlOne[`CMPCTL_C1_NEG_HI:`CMPCTL_C1_NEG_LO];

    // ------------------------------------------------------------
    // Pin and gate
    // ------------------------------------------------------------
    // The raw result goes out so the pin sees no instruction-cycle delay.
    assign pinOut = resultPinEn ? compResult : portLatch;
    assign pinOe  = ~pinDirectionBit & (resultPinEn ? compEnable : 1'b1);
    assign gateSource     = resultSync;
    assign gateSyncEnable = compControlZero[`CMPCTL_C0_SYNC];

    // ------------------------------------------------------------
    // Register writes and interrupt flags
    // ------------------------------------------------------------
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            compControlZero <= `CMPCTL_RST_CTRL0;
            compControlOne  <= `CMPCTL_RST_CTRL1;
            mask            <= 2'h0;
        end else if (regWr) begin
            if (regAddr == `CMPCTL_ADDR_CTRL0) begin
                compControlZero <= regWdata & 8'hB7;
            end else if (regAddr == `CMPCTL_ADDR_CTRL1) begin
                compControlOne <= regWdata & 8'hDB;
            end else if (regAddr == `CMPCTL_ADDR_MASK) begin
                mask <= regWdata[1:0];
            end
        end
    end

    // A read clears the flags, but an edge in that same cycle still lands.
    wire statusRead = regRd & (regAddr == `CMPCTL_ADDR_STATUS);

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            status <= 2'h0;
        end else begin
            status[`CMPCTL_ST_RISE] <= riseEvent |
                (status[`CMPCTL_ST_RISE] & ~statusRead);
            status[`CMPCTL_ST_FALL] <= fallEvent |
                (status[`CMPCTL_ST_FALL] & ~statusRead);
        end
    end

    assign irq = |(status & mask);

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            regRdata <= 8'h00;
        end else if (regRd) begin
            if (regAddr == `CMPCTL_ADDR_CTRL0) begin
                regRdata <= {compControlZero[7], resultSync, compControlZero[5:0]};
            end else if (regAddr == `CMPCTL_ADDR_CTRL1) begin
                regRdata <= compControlOne;
            end else if (regAddr == `CMPCTL_ADDR_MIRROR) begin
                regRdata <= {7'h00, resultSync};
            end else if (regAddr == `CMPCTL_ADDR_STATUS) begin
                regRdata <= {6'h00, status};
            end else if (regAddr == `CMPCTL_ADDR_MASK) begin
                regRdata <= {6'h00, mask};
            end else begin
                regRdata <= 8'h00;
            end
        end else begin
            regRdata <= 8'h00;
        end
    end

endmodule // cmpctl_top

// >>> rtl/cmpctl_map.vh
`ifndef CMPCTL_MAP_VH
`define CMPCTL_MAP_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CMPCTL_ADDR_CTRL0   8'h9D
`define CMPCTL_ADDR_CTRL1   8'h9E
`define CMPCTL_ADDR_MIRROR  8'h9F
`define CMPCTL_ADDR_STATUS  8'hA0
`define CMPCTL_ADDR_MASK    8'hA1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CMPCTL_RST_CTRL0    8'h04
`define CMPCTL_RST_CTRL1    8'h00
`define CMPCTL_RST_MASK     8'h00

// ----------------------------------------------------------------
// Control register zero fields
// ----------------------------------------------------------------
`define CMPCTL_C0_ENABLE    7
`define CMPCTL_C0_RESULT    6
`define CMPCTL_C0_PINEN     5
`define CMPCTL_C0_INVERT    4
`define CMPCTL_C0_SPEED     2
`define CMPCTL_C0_HYST      1
`define CMPCTL_C0_SYNC      0

// ----------------------------------------------------------------
// Control register one fields
// ----------------------------------------------------------------
`define CMPCTL_C1_RISE      7
`define CMPCTL_C1_FALL      6
`define CMPCTL_C1_POS_HI    4
`define CMPCTL_C1_POS_LO    3
`define CMPCTL_C1_NEG_HI    1
`define CMPCTL_C1_NEG_LO    0

// ----------------------------------------------------------------
// Mirror and status fields
// ----------------------------------------------------------------
`define CMPCTL_MIR_RESULT   0
`define CMPCTL_ST_RISE      0
`define CMPCTL_ST_FALL      1

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CMPCTL_CLKS_PER_CYCLE 4

`endif

// >>> rtl/cmpctl_cycle_tick.v
`timescale 1ns/1ps

// Divides the clock into instruction cycles, one tick pulse per cycle.
module cmpctl_cycle_tick #(
    parameter CLKS = 4
) (
    // Clock and reset
    input  wire ref_clk,
    input  wire arst_n,
    // Tick
    output wire tick
);

    reg  [7:0] count;

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            count <= 8'h00;
        end else if (count == CLKS[7:0] - 8'h01) begin
            count <= 8'h00;
        end else begin
            count <= count + 8'h01;
        end
    end

    assign tick = (count == CLKS[7:0] - 8'h01);

endmodule // cmpctl_cycle_tick

// >>> tb/cmpctl_props.sv
`timescale 1ns/1ps
// ---
// Port-level checks of the comparator control block
// ---
module cmpctl_props (
    input wire logic       ref_clk, arst_n, regWr, regRd, analogRaw, analogEnable, portLatch,
    input wire logic       speedPowerSelect, hysteresisEnable, pinDirectionBit, pinOut, pinOe,
    input wire logic       gateSource, irq,
    input wire logic [7:0] regAddr, regWdata, regRdata
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);
    sequence sOff;
        !analogEnable [*6];
    endsequence
    sequence sMirRd;
        regRd && regAddr == 8'h9F;
    endsequence
    a_mirror_width: assert property (sMirRd |=> regRdata[7:1] == 7'h00)
        else $error("mirror upper bits not zero");
    a_off_zero: assert property (sOff ##0 sMirRd |=> !regRdata[0])
        else $error("disabled comparator reads one");
    a_ctrl_write: assert property (regWr && regAddr == 8'h9D |=>
        {analogEnable, 4'h0, speedPowerSelect, hysteresisEnable, 1'h0} == ($past(regWdata) & 8'h86))
        else $error("control write not applied");
    a_reset_state: assert property ($rose(arst_n) |-> speedPowerSelect && !irq)
        else $error("wrong state after reset");
    a_pin_direction: assert property (pinOe |-> !pinDirectionBit)
        else $error("pin driven while set as input");
    a_pin_override: assert property (!analogEnable && pinOut != portLatch |-> !pinOut)
        else $error("override shows a one while off");
    // A registered pin path would move here with no input change.
    a_pin_direct: assert property ($stable(analogRaw) && $stable(portLatch) && !$past(regWr)
        |-> $stable(pinOut)) else $error("pin changed without cause");
    a_gate_hold: assert property ($changed(gateSource) |=> $stable(gateSource) [*3])
        else $error("gate source changed within a cycle");
endmodule // cmpctl_props

bind cmpctl_top cmpctl_props u_props (.ref_clk, .arst_n, .regWr, .regRd, .analogRaw, .analogEnable,
    .portLatch, .speedPowerSelect, .hysteresisEnable, .pinDirectionBit, .pinOut, .pinOe,
    .gateSource, .irq, .regAddr, .regWdata, .regRdata);

// >>> tb/cmpctl_analog_model.sv
`timescale 1ns/1ps
module cmpctl_analog_model (
    input  wire logic       ref_clk,
    input  wire logic       analogEnable,
    input  wire logic [1:0] positiveInput, negativeInput,
    input  wire logic [7:0] chanLevel [4],
    output logic            analogRaw
);
    logic junk = 1'h0;
    // A powered-down comparator gives no usable level, so it shows a toggling pattern.
    always @(posedge ref_clk) junk <= !junk;
    assign analogRaw = analogEnable ?
        (chanLevel[negativeInput] < chanLevel[positiveInput]) : junk;
endmodule // cmpctl_analog_model

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic       ref_clk = 1'h0, arst_n = 1'h0, regWr = 1'h0, regRd = 1'h0, rdPend = 1'h0;
    logic       pinDirectionBit = 1'h0, portLatch = 1'h1, analogRaw, analogEnable, irq;
    logic       speedPowerSelect, hysteresisEnable, pinOut, pinOe, gateSource, gateSyncEnable;
    logic [1:0] positiveInput, negativeInput;
    logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, d, expQ [$];
    logic [7:0] chanLevel [4] = '{8'h10, 8'h80, 8'h40, 8'hC0};
    int         failures = 0, comparisons = 0;
    always #10 ref_clk = !ref_clk;
    cmpctl_top dut (.ref_clk, .arst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .analogRaw,
        .analogEnable, .speedPowerSelect, .hysteresisEnable, .positiveInput, .negativeInput,
        .pinDirectionBit, .portLatch, .pinOut, .pinOe, .gateSource, .gateSyncEnable, .irq);
    cmpctl_analog_model far (.ref_clk, .analogEnable, .positiveInput, .negativeInput,
        .chanLevel, .analogRaw);
    task chk(input logic [7:0] e, input logic [7:0] a);
        comparisons++;
        if (a !== e) begin
            failures++;
            $display("unexpected at %0t: %h expected %h", $time, a, e);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        regWr <= w;
        regRd <= !w;
        regAddr <= a;
        regWdata <= v;
        if (!w) expQ.push_back(v);
        @(posedge ref_clk);
        regWr <= 1'h0;
        regRd <= 1'h0;
    endtask
    always @(posedge ref_clk) rdPend <= regRd;
    // Read data is taken mid-cycle, away from the edges that launch and clear it.
    always @(negedge ref_clk) begin
        if (rdPend) chk(expQ.pop_front(), regRdata);
    end
    task stop_test;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // The whole sequence needs about two hundred cycles, so this only fires on a hang.
    initial begin
        #100000;
        failures++;
        stop_test;
    end
    initial begin
        void'($urandom(32'h2826));
        repeat (3) @(posedge ref_clk);
        arst_n <= 1'h1;
        bus(1'h1, 8'h10, 8'hFF);
        bus(1'h0, 8'h9D, 8'h04);
        bus(1'h0, 8'h9F, 8'h00);
        bus(1'h0, 8'h10, 8'h00);
        d = 8'($urandom);
        bus(1'h1, 8'h9E, d);
        bus(1'h0, 8'h9E, d & 8'hDB);
        chk({4'h0, d[4:3], d[1:0]}, {4'h0, positiveInput, negativeInput});
        for (int i = 0; i < 4; i++) begin
            bus(1'h1, 8'h9E, i[0] ? 8'h01 : 8'h08);
            bus(1'h1, 8'h9D, {3'h5, i[1], 4'h0});
            repeat (12) @(negedge ref_clk);
            d = {7'h00, !i[0] ^ i[1]};
            chk({5'h00, 1'h1, d[0], d[0]}, {5'h00, pinOe, pinOut, gateSource});
            bus(1'h0, 8'h9F, d);
            bus(1'h0, 8'h9D, {1'h1, d[0], 1'h1, i[1], 4'h0});
        end
        bus(1'h1, 8'h9D, 8'h20);
        @(negedge ref_clk);
        chk(8'h00, {6'h00, pinOe, pinOut});
        bus(1'h1, 8'h9D, 8'h00);
        pinDirectionBit <= 1'h1;
        @(negedge ref_clk);
        chk(8'h01, {6'h00, pinOe, pinOut});
        @(posedge ref_clk);
        portLatch <= 1'h0;
        @(negedge ref_clk);
        chk(8'h00, {6'h00, pinOe, pinOut});
        d = 8'($urandom) & 8'h37 | 8'h01;
        bus(1'h1, 8'h9D, d);
        bus(1'h0, 8'h9D, d);
        chk({5'h00, d[2:0]}, {5'h00, speedPowerSelect, hysteresisEnable, gateSyncEnable});
        bus(1'h1, 8'h9E, 8'hC1);
        bus(1'h1, 8'hA1, 8'h03);
        bus(1'h1, 8'h9D, 8'h80);
        repeat (12) @(negedge ref_clk);
        chk(8'h00, {7'h00, irq});
        bus(1'h1, 8'h9E, 8'hC8);
        repeat (12) @(negedge ref_clk);
        chk(8'h01, {7'h00, irq});
        bus(1'h0, 8'hA0, 8'h01);
        bus(1'h1, 8'hA1, 8'h01);
        bus(1'h1, 8'h9E, 8'hC1);
        repeat (12) @(negedge ref_clk);
        chk(8'h00, {7'h00, irq});
        bus(1'h0, 8'hA0, 8'h02);
        bus(1'h0, 8'hA0, 8'h00);
        // A rise with only the falling edge selected, then a fall with only rising selected.
        bus(1'h1, 8'h9E, 8'h48);
        repeat (12) @(negedge ref_clk);
        bus(1'h0, 8'hA0, 8'h00);
        bus(1'h1, 8'h9E, 8'h81);
        repeat (12) @(negedge ref_clk);
        bus(1'h0, 8'hA0, 8'h00);
        repeat (2) @(posedge ref_clk);
        stop_test;
    end
endmodule // tb_top
